//--- led_boost_params.svh
`ifndef LED_BOOST_PARAMS_SVH
`define LED_BOOST_PARAMS_SVH

// Clock and timing figures
`define CLK_MHZ 20
`define CLK_PERIOD_NS 50
`define T_ENABLE_US 500
`define T_SHUTDOWN_US 32000
`define T_MAX_ON_NS 6000
`define T_MIN_OFF_NS 400
`define T_BLANK_NS 400
`define SS_STEP_CYCLES 256

// Peak current limit select codes
`define ILIM_OFF 2'h0
`define ILIM_QUARTER 2'h1
`define ILIM_HALF 2'h2
`define ILIM_FULL 2'h3

// Register byte addresses
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_SWITCH_COUNT 8'h08

// Field positions and the control reset value
`define CONTROL_RUN_BIT 0
`define CONTROL_RESET 32'h0000_0001
`define STAT_ENABLED_BIT 0
`define STAT_MAIN_BIT 1
`define STAT_LED_BIT 2
`define STAT_OVP_BIT 3
`define STAT_UVLO_BIT 4
`define STAT_OTP_BIT 5
`define STAT_ILIM_LSB 6
`define STAT_BLANK_BIT 8

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- led_boost_pkg.sv
package led_boost_pkg;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_ON = 3'b010,
    SW_MIN_OFF = 3'b100
  } switch_state_e;

  typedef enum logic [1:0] {
    EN_SHUTDOWN = 2'b01,
    EN_RUNNING = 2'b10
  } enable_state_e;

  typedef logic [1:0] ilim_sel_t;

endpackage

//--- enable_dim_if.sv
`timescale 1ns/1ps
interface enable_dim_if;
  logic ctrl_level;
  logic fault;
  logic enabled;
  logic led_closed;
  logic blanking;

  modport timer (
    input ctrl_level,
    input fault,
    output enabled,
    output led_closed,
    output blanking
  );

  modport core (
    output ctrl_level,
    output fault,
    input enabled,
    input led_closed,
    input blanking
  );
endinterface

//--- enable_dim_timer.sv
`timescale 1ns/1ps
`include "led_boost_params.svh"
module enable_dim_timer
  import led_boost_pkg::*;
#(
  parameter int ENABLE_CYC = `T_ENABLE_US * `CLK_MHZ,
  parameter int SHUTDOWN_CYC = `T_SHUTDOWN_US * `CLK_MHZ
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  enable_dim_if.timer ed // Enable and dimming link to the core
);

  localparam int BLANK_CYC = (`T_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  enable_state_e state_ff, nxt_state;
  logic [19:0] high_cnt_ff;
  logic [19:0] low_cnt_ff;
  logic [4:0] blank_cnt_ff;
  logic led_ff, nxt_led;
  logic en_done, sd_done;

  assign en_done = ed.ctrl_level && (high_cnt_ff == 20'(ENABLE_CYC - 1));
  assign sd_done = !ed.ctrl_level && (low_cnt_ff == 20'(SHUTDOWN_CYC - 1));

  // Length of the current high and low stretch of the input
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !ed.ctrl_level || ed.fault) begin
      high_cnt_ff <= 20'h0;
    end else if (high_cnt_ff != 20'(ENABLE_CYC - 1)) begin
      high_cnt_ff <= high_cnt_ff + 20'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || ed.ctrl_level) begin
      low_cnt_ff <= 20'h0;
    end else if (low_cnt_ff != 20'(SHUTDOWN_CYC - 1)) begin
      low_cnt_ff <= low_cnt_ff + 20'h1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EN_SHUTDOWN: begin
        if (en_done && !ed.fault) begin
          nxt_state = EN_RUNNING;
        end
      end
      EN_RUNNING: begin
        if (sd_done || ed.fault) begin
          nxt_state = EN_SHUTDOWN;
        end
      end
      default: nxt_state = EN_SHUTDOWN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= EN_SHUTDOWN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // LED return switch follows the input while running
  assign nxt_led = (nxt_state == EN_RUNNING) && ed.ctrl_level && !ed.fault;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      led_ff <= 1'b0;
    end else begin
      led_ff <= nxt_led;
    end
  end

  // Error comparator blanking after each closing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      blank_cnt_ff <= 5'h0;
    end else if (nxt_led && !led_ff) begin
      blank_cnt_ff <= 5'(BLANK_CYC);
    end else if (blank_cnt_ff != 5'h0) begin
      blank_cnt_ff <= blank_cnt_ff - 5'h1;
    end
  end

  assign ed.enabled = (state_ff == EN_RUNNING);
  assign ed.led_closed = led_ff;
  assign ed.blanking = (blank_cnt_ff != 5'h0);

endmodule

//--- led_boost_pfm_control.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "led_boost_params.svh"
module led_boost_pfm_control
  import led_boost_pkg::*;
#(
  parameter int ENABLE_CYC = `T_ENABLE_US * `CLK_MHZ,
  parameter int SHUTDOWN_CYC = `T_SHUTDOWN_US * `CLK_MHZ
) (
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ctrl_in, // Combined enable and dimming pin
  input wire logic fb_below_ref, // Feedback sense below reference
  input wire logic peak_reached, // Inductor current at selected limit
  input wire logic ovp_above, // Output overvoltage sense above threshold
  input wire logic uvlo_active, // Undervoltage lockout indication
  input wire logic otp_active, // Over-temperature indication
  output logic main_power_switch, // Main power switch gate, high closes
  output logic led_return_switch, // LED return switch gate, high closes
  output ilim_sel_t ilim_sel, // Peak current limit select
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read data valid
  input wire logic s_axi_rready // AXI read data ready
);

  localparam int MAX_ON_CYC = `T_MAX_ON_NS / `CLK_PERIOD_NS;
  localparam int MIN_OFF_CYC = (`T_MIN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int NPIN = 6;

  // Pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_ff;
  logic [NPIN-1:0] pin_sync_ff;
  logic ctrl_s, fb_s, peak_s, ovp_s, uvlo_s, otp_s;

  assign pin_raw = {otp_active, uvlo_active, ovp_above, peak_reached, fb_below_ref, ctrl_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pin_meta_ff[gi] <= 1'b0;
          pin_sync_ff[gi] <= 1'b0;
        end else begin
          pin_meta_ff[gi] <= pin_raw[gi];
          pin_sync_ff[gi] <= pin_meta_ff[gi];
        end
      end
    end
  endgenerate

  assign ctrl_s = pin_sync_ff[0];
  assign fb_s = pin_sync_ff[1];
  assign peak_s = pin_sync_ff[2];
  assign ovp_s = pin_sync_ff[3];
  assign uvlo_s = pin_sync_ff[4];
  assign otp_s = pin_sync_ff[5];

  // Enable, shutdown and dimming timer
  enable_dim_if ed ();

  assign ed.ctrl_level = ctrl_s;
  assign ed.fault = uvlo_s || otp_s;

  enable_dim_timer #(
    .ENABLE_CYC(ENABLE_CYC),
    .SHUTDOWN_CYC(SHUTDOWN_CYC)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ed(ed)
  );

  // Software control register
  logic [31:0] control_ff;
  logic run_en;

  assign run_en = control_ff[`CONTROL_RUN_BIT];

  // Main switch state machine
  switch_state_e sw_state_ff, nxt_sw_state;
  logic [6:0] on_cnt_ff;
  logic [3:0] off_cnt_ff;
  logic force_off, fb_valid, on_timeout, min_off_done, turn_on;
  logic main_sw_ff;

  assign force_off = !ed.enabled || ed.fault || ovp_s || !run_en;
  assign fb_valid = fb_s && !ed.blanking;
  assign on_timeout = (on_cnt_ff == 7'(MAX_ON_CYC - 1));
  assign min_off_done = (off_cnt_ff == 4'(MIN_OFF_CYC - 1));

  always_comb begin
    nxt_sw_state = sw_state_ff;
    case (sw_state_ff)
      SW_IDLE: begin
        if (!force_off && fb_valid) begin
          nxt_sw_state = SW_ON;
        end
      end
      SW_ON: begin
        if (force_off || peak_s || on_timeout) begin
          nxt_sw_state = SW_MIN_OFF;
        end
      end
      SW_MIN_OFF: begin
        if (min_off_done) begin
          nxt_sw_state = SW_IDLE;
        end
      end
      default: nxt_sw_state = SW_IDLE;
    endcase
  end

  assign turn_on = (sw_state_ff == SW_IDLE) && (nxt_sw_state == SW_ON);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sw_state_ff <= SW_IDLE;
      main_sw_ff <= 1'b0;
    end else begin
      sw_state_ff <= nxt_sw_state;
      main_sw_ff <= (nxt_sw_state == SW_ON);
    end
  end

  // On-time and off-time counters
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sw_state_ff != SW_ON) begin
      on_cnt_ff <= 7'h0;
    end else if (!on_timeout) begin
      on_cnt_ff <= on_cnt_ff + 7'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || sw_state_ff != SW_MIN_OFF) begin
      off_cnt_ff <= 4'h0;
    end else if (!min_off_done) begin
      off_cnt_ff <= off_cnt_ff + 4'h1;
    end
  end

  // Softstart: switch cycles since enable, saturating at two steps
  logic [9:0] ss_cnt_ff;
  ilim_sel_t ilim_ff, nxt_ilim;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !ed.enabled || ed.fault) begin
      ss_cnt_ff <= 10'h0;
    end else if (turn_on && ss_cnt_ff != 10'(2 * `SS_STEP_CYCLES)) begin
      ss_cnt_ff <= ss_cnt_ff + 10'h1;
    end
  end

  always_comb begin
    if (!ed.enabled) begin
      nxt_ilim = `ILIM_OFF;
    end else if (ss_cnt_ff < 10'(`SS_STEP_CYCLES)) begin
      nxt_ilim = `ILIM_QUARTER;
    end else if (ss_cnt_ff < 10'(2 * `SS_STEP_CYCLES)) begin
      nxt_ilim = `ILIM_HALF;
    end else begin
      nxt_ilim = `ILIM_FULL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ilim_ff <= `ILIM_OFF;
    end else begin
      ilim_ff <= nxt_ilim;
    end
  end

  // Count of switch cycles for software
  logic [31:0] sw_count_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sw_count_ff <= 32'h0;
    end else if (turn_on) begin
      sw_count_ff <= sw_count_ff + 32'h1;
    end
  end

  assign main_power_switch = main_sw_ff;
  assign led_return_switch = ed.led_closed;
  assign ilim_sel = ilim_ff;

  // AXI4-Lite write path: address and data taken in either order
  logic awready_ff, wready_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff, w_held_ff;
  logic do_write;

  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      waddr_ff <= 8'h0;
    end else if (s_axi_awvalid && awready_ff) begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      waddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else begin
      awready_ff <= !aw_held_ff && !bvalid_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else begin
      wready_ff <= !w_held_ff && !bvalid_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      control_ff <= `CONTROL_RESET;
    end else if (do_write && waddr_ff == `REG_CONTROL && wstrb_ff[0]) begin
      control_ff[`CONTROL_RUN_BIT] <= wdata_ff[`CONTROL_RUN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      case (waddr_ff)
        `REG_CONTROL, `REG_STATUS, `REG_SWITCH_COUNT: bresp_ff <= `RESP_OKAY;
        default: bresp_ff <= `RESP_SLVERR;
      endcase
    end else if (s_axi_bready && bvalid_ff) begin
      bvalid_ff <= 1'b0;
    end
  end

  // AXI4-Lite read path
  logic arready_ff, rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff, status_word;

  always_comb begin
    status_word = 32'h0;
    status_word[`STAT_ENABLED_BIT] = ed.enabled;
    status_word[`STAT_MAIN_BIT] = main_sw_ff;
    status_word[`STAT_LED_BIT] = ed.led_closed;
    status_word[`STAT_OVP_BIT] = ovp_s;
    status_word[`STAT_UVLO_BIT] = uvlo_s;
    status_word[`STAT_OTP_BIT] = otp_s;
    status_word[`STAT_ILIM_LSB +: 2] = ilim_ff;
    status_word[`STAT_BLANK_BIT] = ed.blanking;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      case (s_axi_araddr)
        `REG_CONTROL: begin
          rdata_ff <= control_ff;
          rresp_ff <= `RESP_OKAY;
        end
        `REG_STATUS: begin
          rdata_ff <= status_word;
          rresp_ff <= `RESP_OKAY;
        end
        `REG_SWITCH_COUNT: begin
          rdata_ff <= sw_count_ff;
          rresp_ff <= `RESP_OKAY;
        end
        default: begin
          rdata_ff <= 32'h0;
          rresp_ff <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end else begin
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

//--- led_boost_pfm_control_checker.sv
`timescale 1ns/1ps
module led_boost_pfm_control_checker (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic ctrl_in, // Dimming pin
  input wire logic peak_reached, // Peak current
  input wire logic ovp_above, // Overvoltage
  input wire logic uvlo_active, // Undervoltage
  input wire logic otp_active, // Overtemperature
  input wire logic main_power_switch, // Main switch
  input wire logic led_return_switch // LED switch
);
  logic [7:0] on_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Consecutive cycles with the main switch closed
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !main_power_switch) begin
      on_ff <= 8'h00;
    end else begin
      on_ff <= on_ff + 8'h01;
    end
  end
  sequence s_opened;
    !main_power_switch && !led_return_switch;
  endsequence
  sequence s_ctrl_low;
    !ctrl_in [*4];
  endsequence
  a_uvlo_opens: assert property (uvlo_active [*4] |=> s_opened)
    else $error("switches closed during undervoltage");
  a_otp_opens: assert property (otp_active [*4] |=> s_opened)
    else $error("switches closed during overtemperature");
  a_peak_stops: assert property (peak_reached [*4] |=> !main_power_switch)
    else $error("main switch on at peak current");
  a_ovp_holds: assert property (ovp_above [*4] |=> !main_power_switch)
    else $error("main switch on during overvoltage");
  a_max_on: assert property (on_ff <= 8'h78)
    else $error("main switch on too long");
  a_min_off: assert property ($fell(main_power_switch) |-> !main_power_switch [*8])
    else $error("off time too short");
  a_led_rise: assert property ($rose(led_return_switch) |-> $past(ctrl_in, 3))
    else $error("LED switch closed without input high");
  a_led_low: assert property (s_ctrl_low |=> !led_return_switch)
    else $error("LED switch closed with input low");
endmodule
bind led_boost_pfm_control led_boost_pfm_control_checker chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .ctrl_in(ctrl_in), .peak_reached(peak_reached),
  .ovp_above(ovp_above), .uvlo_active(uvlo_active), .otp_active(otp_active),
  .main_power_switch(main_power_switch), .led_return_switch(led_return_switch)
);

//--- pwm_source.sv
`timescale 1ns/1ps
module pwm_source (
  input wire logic sys_clk, // Clock
  input wire logic [15:0] hi_len, // High cycles, 0 holds low
  input wire logic [15:0] lo_len, // Low cycles, 0 holds high
  output logic ctrl_in // Enable and dimming level
);
  logic [15:0] cnt_ff;
  always @(posedge sys_clk) begin
    if (hi_len == 16'h0000) begin
      ctrl_in <= 1'b0;
      cnt_ff <= 16'h0000;
    end else if (lo_len == 16'h0000) begin
      ctrl_in <= 1'b1;
      cnt_ff <= 16'h0000;
    end else if (cnt_ff + 16'h0001 >= (ctrl_in ? hi_len : lo_len)) begin
      ctrl_in <= !ctrl_in;
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule

//--- led_boost_pfm_control_bench.sv
`timescale 1ns/1ps
`include "led_boost_params.svh"
module led_boost_pfm_control_bench;
  import led_boost_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fb = 1'b0, peak = 1'b0, output_overvoltage_sense = 1'b0, uvlo = 1'b0, otp = 1'b0;
  logic ctrl, main_sw, led_sw;
  ilim_sel_t ilim;
  logic [15:0] hi_len = 16'h0000, lo_len = 16'h0000;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [4:0] h;
  int miscompares = 0, n_checks = 0, n, k;
  always #25 sys_clk = ~sys_clk;
  pwm_source src_u (.sys_clk(sys_clk), .hi_len(hi_len), .lo_len(lo_len), .ctrl_in(ctrl));
  led_boost_pfm_control #(.ENABLE_CYC(20), .SHUTDOWN_CYC(40)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .ctrl_in(ctrl), .fb_below_ref(fb),
    .peak_reached(peak), .ovp_above(output_overvoltage_sense), .uvlo_active(uvlo), .otp_active(otp),
    .main_power_switch(main_sw), .led_return_switch(led_sw), .ilim_sel(ilim),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int i);
    if (i >= 2000) begin
      miscompares++;
      results();
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Wait for the main (w=0) or LED (w=1) switch to reach v
  task automatic wsig(input bit w, input logic v);
    int i;
    for (i = 0; i < 2000 && (w ? led_sw : main_sw) !== v; i++) cyc(1);
    tmo(i);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv);
    int i;
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 2000; i++) begin
      cyc(1);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(i);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 2000; i++) begin
      cyc(1);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(i);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic t_enable();
    lo_len <= 16'h0000;
    hi_len <= 16'h0001;
    cyc(15);
    chk("led early", led_sw, 0);
    wsig(1, 1);
    cyc(100);
    chk("led held", led_sw, 1);
    axi_rd(`REG_STATUS);
    chk("enabled", d[0], 1);
    $display("enable done");
  endtask
  task automatic t_switch();
    fb <= 1'b1;
    wsig(0, 1);
    chk("ilim", ilim, `ILIM_QUARTER);
    peak <= 1'b1;
    wsig(0, 0);
    peak <= 1'b0;
    for (n = 0; n < 40 && !main_sw; n++) cyc(1);
    chk("off gap", n inside {[7:12]}, 1);
    for (n = 1; n < 300 && main_sw; n++) cyc(1);
    chk("on time", n - 1, 120);
    fb <= 1'b0;
    output_overvoltage_sense <= 1'b1;
    cyc(4);
    fb <= 1'b1;
    cyc(30);
    chk("ovp off", main_sw, 0);
    output_overvoltage_sense <= 1'b0;
    wsig(0, 1);
    peak <= 1'b1;
    axi_wr(`REG_CONTROL, 32'h0000_0000);
    peak <= 1'b0;
    chk("wr resp", r, `RESP_OKAY);
    cyc(30);
    chk("run off", main_sw, 0);
    fb <= 1'b0;
    axi_wr(`REG_CONTROL, 32'h0000_0001);
    axi_rd(8'h40);
    chk("unmapped", {d, r}, {32'h0000_0000, `RESP_SLVERR});
    $display("switch done");
  endtask
  task automatic t_fault();
    for (k = 0; k < 2; k++) begin
      if (k == 0) uvlo <= 1'b1;
      else otp <= 1'b1;
      cyc(5);
      chk("fault open", {main_sw, led_sw}, 0);
      uvlo <= 1'b0;
      otp <= 1'b0;
      cyc(15);
      chk("relock", led_sw, 0);
      fb <= 1'b1;
      wsig(1, 1);
      for (n = 0; n < 40 && !main_sw; n++) cyc(1);
      chk("blank gap", n inside {[8:12]}, 1);
    end
    $display("fault done");
  endtask
  task automatic t_soft();
    fb <= 1'b1;
    for (k = 0; k < 520; k++) begin
      wsig(0, 1);
      chk("ilim step", ilim, k < 256 ? `ILIM_QUARTER : k < 512 ? `ILIM_HALF : `ILIM_FULL);
      peak <= 1'b1;
      wsig(0, 0);
      peak <= 1'b0;
    end
    fb <= 1'b0;
    $display("softstart done");
  endtask
  task automatic t_pwm();
    hi_len <= 16'd30;
    lo_len <= 16'd30;
    h = 5'h00;
    for (k = 0; k < 300; k++) begin
      cyc(1);
      h = {h[3:0], ctrl};
      if (k > 10 && h[2] == h[4]) chk("led follow", led_sw, h[3]);
    end
    $display("pwm done");
  endtask
  task automatic t_shut();
    hi_len <= 16'h0000;
    cyc(30);
    axi_rd(`REG_STATUS);
    chk("still on", d[0], 1);
    cyc(30);
    axi_rd(`REG_STATUS);
    chk("disabled", {d[0], led_sw}, 0);
    lo_len <= 16'h0000;
    hi_len <= 16'h0001;
    wsig(1, 1);
    cyc(1);
    chk("ss restart", ilim, `ILIM_QUARTER);
    $display("shutdown done");
  endtask
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(2);
    t_enable();
    t_switch();
    t_fault();
    t_soft();
    t_pwm();
    t_shut();
    results();
  end
endmodule
